// ---- hdl/dpt_pkg.sv ----
/*
 digital port trigger package: constants, pin functions, apb register map.
 assumes a 100 MHz pclk and a seven pin digital port.
*/
package dpt_pkg;
    localparam int          NPINS        = 7;
    localparam int          CLK_MHZ      = 100;
    localparam int          TRIG_LAT_US  = 5;
    localparam int          MIN_PW_US    = 2;
    localparam int          OUT_PW_US    = 10;
    localparam int          OUT_PW_CYC   = OUT_PW_US * CLK_MHZ;
    localparam int          LAT_CYC      = TRIG_LAT_US * CLK_MHZ;
    localparam int          SYNC_LO_PIN  = 4;
    localparam int          SYNC_HI_PIN  = 7;
    // pin function codes, 3 bits per pin
    localparam logic [2:0]  FN_DIN       = 3'h0;
    localparam logic [2:0]  FN_TRIG_IN   = 3'h1;
    localparam logic [2:0]  FN_TRIG_OUT  = 3'h2;
    localparam logic [2:0]  FN_ON_SYNC   = 3'h3;
    localparam logic [2:0]  FN_OFF_SYNC  = 3'h4;
    // register byte offsets
    localparam logic [7:0]  REG_FUNC     = 8'h00;
    localparam logic [7:0]  REG_POL      = 8'h04;
    localparam logic [7:0]  REG_CTRL     = 8'h08;
    localparam logic [7:0]  REG_STAT     = 8'h0C;
    localparam logic [7:0]  REG_PINS     = 8'h10;
    localparam logic [20:0] FUNC_RST     = 21'h000000;
    localparam logic [6:0]  POL_RST      = 7'h00;
    localparam int          CTRL_EXT_BIT = 0;
    localparam int          CTRL_SW_BIT  = 1;
    localparam int          STAT_REJ_BIT = 0;
    localparam int          STAT_TIN_BIT = 1;
    typedef enum logic [2:0] {
        DPT_IDLE  = 3'b001,
        DPT_SETUP = 3'b010,
        DPT_ACC   = 3'b100
    } dpt_apb_e;
endpackage

// ---- hdl/dpt_edge_in.sv ----
/*
 synchronises one trigger input and detects the selected edge.
 assumes pin is asynchronous to pclk.
*/
`timescale 1ns/10ps
module dpt_edge_in (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin side
    input  wire logic pin_i,
    input  wire logic pol_neg,
    input  wire logic enable,
    // event
    output logic      event_o
);
    import dpt_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } dpt_sync_s;
    dpt_sync_s st_q, st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // rising when positive, falling when negative
    assign event_o = enable &&
        (pol_neg ? (st_q.s3 & ~st_q.s2)
                 : (~st_q.s3 & st_q.s2));

    a_edge_one_shot: assert property (
        @(posedge pclk) disable iff (!presetn)
        event_o |=> !event_o) else $error("edge event repeated");
endmodule

// ---- hdl/dpt_pulse_out.sv ----
/*
 fixed width pulse generator for one trigger output.
 assumes single cycle fire requests.
*/
`timescale 1ns/10ps
module dpt_pulse_out #(
    parameter int WIDTH_CYC = dpt_pkg::OUT_PW_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // request
    input  wire logic fire,
    // pulse
    output logic      active_o
);
    import dpt_pkg::*;
    typedef struct packed {
        logic [15:0] cnt;
    } dpt_pulse_s;
    dpt_pulse_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (fire) begin
            st_d.cnt = 16'(WIDTH_CYC);
        end else if (st_q.cnt != 16'h0000) begin
            st_d.cnt = st_q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign active_o = (st_q.cnt != 16'h0000);

    a_pulse_width: assert property (
        @(posedge pclk) disable iff (!presetn)
        fire |=> active_o [*8]) else $error("pulse too short");
endmodule

// ---- hdl/dpt_top.sv ----
/*
 digital port trigger block: pin functions, trigger in/out, sync pins,
 apb register file. assumes synchronous apb master on pclk and
 external pin buffers resolving the enable/output pairs.
*/
`timescale 1ns/10ps
module dpt_top (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // digital port pins
    input  wire logic [dpt_pkg::NPINS-1:0] pin_i,
    output logic      [dpt_pkg::NPINS-1:0] pin_o,
    output logic      [dpt_pkg::NPINS-1:0] pin_oe,
    // connectors
    input  wire logic                      ext_trig_in,
    output logic                           ext_trig_out,
    // internal trigger sources and consumers
    input  wire logic                      int_trig,
    input  wire logic                      step_start,
    input  wire logic                      step_trig_flag,
    output logic                           trig_in_event,
    // output couple lines
    input  wire logic                      on_sync_req,
    input  wire logic                      off_sync_req,
    output logic                           on_sync_seen,
    output logic                           off_sync_seen
);
    import dpt_pkg::*;

    typedef struct packed {
        logic [20:0] func;
        logic [6:0]  pol;
        logic        ext_sel;
        logic        rejected;
        logic        tin_seen;
        logic        trig_ev;
        logic [6:0]  pin_out;
        logic [6:0]  pin_en;
        logic        ext_out;
        logic [31:0] rdata;
    } dpt_state_s;

    dpt_state_s st_q, st_d;

    logic [NPINS-1:0] pin_ev;
    logic [NPINS-1:0] pulse_act;
    logic [NPINS-1:0] is_tin;
    logic [NPINS-1:0] is_tout;
    logic [NPINS-1:0] is_on;
    logic [NPINS-1:0] is_off;
    logic             ext_ev;
    logic             fire;
    logic             wr_en;
    logic             rd_en;
    logic             cfg_ok;
    logic [20:0]      new_func;
    logic [3:0]       on_cnt;
    logic [3:0]       off_cnt;
    logic             sync_bad;
    logic             reg_hit;

    assign fire = int_trig | (step_start & step_trig_flag);

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            assign is_tin[g]  = st_q.func[3*g +: 3] == FN_TRIG_IN;
            assign is_tout[g] = st_q.func[3*g +: 3] == FN_TRIG_OUT;
            assign is_on[g]   = st_q.func[3*g +: 3] == FN_ON_SYNC;
            assign is_off[g]  = st_q.func[3*g +: 3] == FN_OFF_SYNC;
            dpt_edge_in u_edge (
                .pclk    (pclk),
                .presetn (presetn),
                .pin_i   (pin_i[g]),
                .pol_neg (st_q.pol[g]),
                .enable  (is_tin[g]),
                .event_o (pin_ev[g])
            );
            dpt_pulse_out #(.WIDTH_CYC(OUT_PW_CYC)) u_pulse (
                .pclk     (pclk),
                .presetn  (presetn),
                .fire     (fire & is_tout[g]),
                .active_o (pulse_act[g])
            );
        end
    endgenerate

    // connector trigger, always rising edge
    dpt_edge_in u_ext_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   (ext_trig_in),
        .pol_neg (1'b0),
        .enable  (st_q.ext_sel),
        .event_o (ext_ev)
    );

    logic ext_act;
    dpt_pulse_out #(.WIDTH_CYC(OUT_PW_CYC)) u_ext_pulse (
        .pclk     (pclk),
        .presetn  (presetn),
        .fire     (fire),
        .active_o (ext_act)
    );

    // proposed function word legality
    always_comb begin
        new_func = pwdata[20:0];
        on_cnt   = 4'h0;
        off_cnt  = 4'h0;
        sync_bad = 1'b0;
        for (int i = 0; i < NPINS; i++) begin
            if (new_func[3*i +: 3] == FN_ON_SYNC) begin
                on_cnt = on_cnt + 4'h1;
            end
            if (new_func[3*i +: 3] == FN_OFF_SYNC) begin
                off_cnt = off_cnt + 4'h1;
            end
            if ((new_func[3*i +: 3] == FN_ON_SYNC ||
                 new_func[3*i +: 3] == FN_OFF_SYNC) &&
                (i + 1 < SYNC_LO_PIN || i + 1 > SYNC_HI_PIN)) begin
                sync_bad = 1'b1;
            end
            if (new_func[3*i +: 3] > FN_OFF_SYNC) begin
                sync_bad = 1'b1;
            end
        end
        cfg_ok = !sync_bad && on_cnt <= 4'h1 && off_cnt <= 4'h1;
    end

    // address decode for the error response
    always_comb begin
        reg_hit = 1'b0;
        case (paddr)
            REG_FUNC, REG_POL, REG_CTRL, REG_STAT, REG_PINS: begin
                reg_hit = 1'b1;
            end
            default: begin
                reg_hit = 1'b0;
            end
        endcase
    end

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    always_comb begin
        st_d          = st_q;
        st_d.trig_ev  = (|pin_ev) | ext_ev;
        if (st_d.trig_ev) begin
            st_d.tin_seen = 1'b1;
        end
        for (int i = 0; i < NPINS; i++) begin
            // sync pins: active low fixed, polarity ignored
            if (st_q.func[3*i +: 3] == FN_ON_SYNC) begin
                st_d.pin_en[i]  = on_sync_req;
                st_d.pin_out[i] = 1'b0;
            end else if (st_q.func[3*i +: 3] == FN_OFF_SYNC) begin
                st_d.pin_en[i]  = off_sync_req;
                st_d.pin_out[i] = 1'b0;
            end else if (is_tout[i]) begin
                st_d.pin_en[i]  = 1'b1;
                st_d.pin_out[i] = pulse_act[i] ^ st_q.pol[i];
            end else begin
                st_d.pin_en[i]  = 1'b0;
                st_d.pin_out[i] = 1'b0;
            end
        end
        st_d.ext_out = ext_act;
        if (wr_en) begin
            case (paddr)
                REG_FUNC: begin
                    if (cfg_ok) begin
                        st_d.func = new_func;
                    end else begin
                        st_d.rejected = 1'b1;
                    end
                end
                REG_POL: begin
                    st_d.pol = pwdata[6:0];
                end
                REG_CTRL: begin
                    st_d.ext_sel = pwdata[CTRL_EXT_BIT];
                end
                REG_STAT: begin
                    // write one to clear, new event wins
                    if (pwdata[STAT_REJ_BIT]) begin
                        st_d.rejected = 1'b0;
                    end
                    if (pwdata[STAT_TIN_BIT] && !st_d.trig_ev) begin
                        st_d.tin_seen = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rd_en) begin
            case (paddr)
                REG_FUNC: st_d.rdata = {11'h000, st_q.func};
                REG_POL:  st_d.rdata = {25'h0000000, st_q.pol};
                REG_CTRL: st_d.rdata = {31'h00000000, st_q.ext_sel};
                REG_STAT: st_d.rdata = {30'h00000000, st_q.tin_seen,
                                        st_q.rejected};
                REG_PINS: st_d.rdata = {25'h0000000, pin_i};
                default:  st_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= '0;
            st_q.func <= FUNC_RST;
            st_q.pol  <= POL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata        = st_q.rdata;
    assign pready        = 1'b1;
    assign pslverr       = psel & penable &
                           (~reg_hit | (pwrite & (paddr == REG_FUNC) &
                           ~cfg_ok));
    assign pin_o         = st_q.pin_out;
    assign pin_oe        = st_q.pin_en;
    assign ext_trig_out  = st_q.ext_out;
    assign trig_in_event = st_q.trig_ev;
    assign on_sync_seen  = |(is_on & ~pin_i);
    assign off_sync_seen = |(is_off & ~pin_i);

    a_tin_latency: assert property (
        @(posedge pclk) disable iff (!presetn)
        (|pin_ev) |=> trig_in_event) else $error("trigger late");
    a_ext_merge: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_ev |=> trig_in_event) else $error("ext trig lost");
    // seen flag must survive a clear in the same cycle
    a_tin_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        trig_in_event |-> st_q.tin_seen) else $error("trigger flag lost");
    a_cfg_reject: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == REG_FUNC && !cfg_ok |=> $stable(st_q.func))
        else $error("bad config taken");
    a_reject_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == REG_FUNC && !cfg_ok |=> st_q.rejected)
        else $error("reject flag missing");
    // pin drive lags the function by one register stage
    a_sync_fixed: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(|($past(is_on | is_off) & pin_o)))
        else $error("sync level wrong");
    a_sync_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(on_sync_req) |-> !(|($past(is_on) & ~pin_oe)))
        else $error("on sync not driven");
    a_tout_drive: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(|($past(is_tout) & ~pin_oe)))
        else $error("trigger output undriven");
    a_sync_range: assert property (
        @(posedge pclk) disable iff (!presetn)
        (is_on[2:0] == 3'h0) && (is_off[2:0] == 3'h0))
        else $error("sync on low pin");
    a_step_fire: assert property (
        @(posedge pclk) disable iff (!presetn)
        step_start && step_trig_flag |=> ##1 ext_trig_out)
        else $error("step trigger missing");
    c_tin: cover property (@(posedge pclk) trig_in_event);
    c_tout: cover property (@(posedge pclk) ext_trig_out);
    c_reject: cover property (@(posedge pclk) st_q.rejected);
    c_step: cover property (@(posedge pclk) step_start && step_trig_flag);
    c_sync: cover property (@(posedge pclk) |(pin_oe & is_on));
endmodule

// ---- sim/dpt_partner.sv ----
/*
 far side equipment: drives the port pins, pulsing one pin on request.
 assumes go is a one cycle request from the bench, after reset.
*/
`timescale 1ns/10ps
module dpt_partner #(
    // bit1 idles high for a negative input, bits 4 and 5 on pull-ups
    parameter logic [6:0] IDLE = 7'h32
) (
    // clock
    input  wire logic       pclk,
    // request
    input  wire logic       go,
    input  wire logic [2:0] idx,
    input  wire logic [7:0] extra,
    // pins
    output logic      [6:0] pin_drv
);
    import dpt_pkg::*;
    int         cnt = 0;
    logic [2:0] held = 3'h0;
    logic [6:0] drv_q = IDLE;
    assign pin_drv = drv_q;
    // pulse held for the minimum width plus a random stretch
    always @(posedge pclk) begin
        if (go) begin
            drv_q[idx] <= ~drv_q[idx];
            held       <= idx;
            cnt        <= MIN_PW_US * CLK_MHZ + extra;
        end else if (cnt == 1) begin
            drv_q[held] <= ~drv_q[held];
            cnt         <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ---- sim/digital_port_trigger_io_tb.sv ----
/*
 bench for the port trigger block: apb master, pin partner, queued
 expectations. assumes full width output pulses.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module digital_port_trigger_io_tb;
    import dpt_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, extra = 0;
    logic [31:0] pwdata = 0, prdata, rnd = 32'h77F9;
    logic        pready, pslverr, ext_trig_in = 0, ext_trig_out;
    logic        int_trig = 0, step_start = 0, step_trig_flag = 0;
    logic        on_sync_req = 0, off_sync_req = 0, go = 0;
    logic        trig_in_event, on_sync_seen, off_sync_seen;
    logic [6:0]  pin_i, pin_o, pin_oe, pin_drv;
    logic [2:0]  idx = 0;
    logic [33:0] e_rd;
    logic [33:0] exp_rd[$];
    int          exp_t[$], exp_w[$], e_t, e_w;
    int          fail_count = 0, comparisons = 0, cyc = 0, wx = 0, wp = 0;

    assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin_drv);
    always #5 pclk = ~pclk;

    dpt_top i_dpt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .ext_trig_in(ext_trig_in),
        .ext_trig_out(ext_trig_out), .int_trig(int_trig),
        .step_start(step_start), .step_trig_flag(step_trig_flag),
        .trig_in_event(trig_in_event), .on_sync_req(on_sync_req),
        .off_sync_req(off_sync_req), .on_sync_seen(on_sync_seen),
        .off_sync_seen(off_sync_seen));
    dpt_partner i_dpt_partner (.pclk(pclk), .go(go), .idx(idx),
        .extra(extra), .pin_drv(pin_drv));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic conclude();
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic e,
                       input logic [31:0] r);
        exp_rd.push_back({!w, e, r});
        @(posedge pclk);
        psel   <= 1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 0;
        penable <= 0;
    endtask

    task automatic pulse(input logic [2:0] i, input logic ex);
        @(posedge pclk);
        go    <= 1;
        idx   <= i;
        extra <= rnd[7:0];
        rnd = xs(rnd);
        if (ex) exp_t.push_back(cyc);
        @(posedge pclk);
        go <= 0;
        repeat (700) @(posedge pclk);
    endtask

    task automatic ext(input logic ex);
        @(posedge pclk);
        ext_trig_in <= 1;
        if (ex) exp_t.push_back(cyc);
        repeat (200) @(posedge pclk);
        ext_trig_in <= 0;
        repeat (600) @(posedge pclk);
    endtask

    task automatic fire(input logic it, input logic ss, input logic fl,
                        input logic ex);
        @(posedge pclk);
        int_trig       <= it;
        step_start     <= ss;
        step_trig_flag <= fl;
        if (ex) exp_w.push_back(OUT_PW_CYC);
        if (ex) exp_w.push_back(OUT_PW_CYC);
        @(posedge pclk);
        int_trig   <= 0;
        step_start <= 0;
        repeat (1100) @(posedge pclk);
    endtask

    // cycle ceiling, about four times the scenario length
    always @(posedge pclk) begin
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end

    // result watcher: every apb completion, event and pulse end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1) begin
            e_rd = exp_rd.pop_front();
            `CHK(pslverr, e_rd[32])
            if (e_rd[33]) `CHK(prdata, e_rd[31:0])
        end
        if (trig_in_event === 1'b1) begin
            if (exp_t.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                e_t = exp_t.pop_front();
                `CHK(cyc - e_t <= LAT_CYC, 1'b1)
            end
        end
        wx <= (ext_trig_out === 1'b1) ? wx + 1 : 0;
        if (ext_trig_out !== 1'b1 && wx > 0) begin
            e_w = (exp_w.size() > 0) ? exp_w.pop_front() : 0;
            `CHK(wx, e_w)
        end
        wp <= (pin_oe[2] === 1'b1 && pin_o[2] === 1'b0) ? wp + 1 : 0;
        if (pin_o[2] !== 1'b0 && wp > 0) begin
            e_w = (exp_w.size() > 0) ? exp_w.pop_front() : 0;
            `CHK(wp, e_w)
        end
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, REG_FUNC, 0, 0, 32'h0);
        apb(0, REG_POL, 0, 0, 32'h0);
        apb(1, 8'h14, rnd, 1, 32'h0);
        apb(0, 8'h14, 0, 1, 32'h0);
        apb(1, REG_POL, 32'h06, 0, 0);
        apb(1, REG_FUNC, 32'h23089, 0, 0);
        apb(1, REG_FUNC, 32'h23083, 1, 0);
        apb(1, REG_FUNC, 32'h1B089, 1, 0);
        apb(0, REG_FUNC, 0, 0, 32'h23089);
        apb(1, REG_FUNC, 32'h103089, 0, 0);
        apb(1, REG_FUNC, 32'h23089, 0, 0);
        apb(0, REG_STAT, 0, 0, 32'h1);
        apb(1, REG_STAT, 32'h1, 0, 0);
        apb(0, REG_STAT, 0, 0, 32'h0);
        apb(0, REG_PINS, 0, 0, 32'h36);
        pulse(3'h0, 1);
        pulse(3'h1, 1);
        pulse(3'h3, 0);
        apb(0, REG_STAT, 0, 0, 32'h2);
        ext(0);
        apb(1, REG_CTRL, 32'h1, 0, 0);
        ext(1);
        pulse(3'h0, 1);
        `CHK(pin_o[2], 1'b1)
        fire(1, 0, 0, 1);
        fire(0, 1, 1, 1);
        fire(0, 1, 0, 0);
        `CHK({on_sync_seen, off_sync_seen}, 2'b00)
        on_sync_req  <= 1;
        off_sync_req <= 1;
        apb(1, REG_POL, 32'h36, 0, 0);
        repeat (3) @(posedge pclk);
        `CHK(pin_o[4], 1'b0)
        `CHK(pin_o[5], 1'b0)
        `CHK(on_sync_seen, 1'b1)
        `CHK(off_sync_seen, 1'b1)
        `CHK(pin_oe[5:4], 2'b11)
        repeat (3) @(posedge pclk);
        `CHK(exp_t.size() + exp_w.size() + exp_rd.size(), 0)
        conclude();
    end
endmodule
